// ---- logic/vfdsc_params.svh ----
// Constants for the serial command port of the display controller.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef VFDSC_PARAMS_SVH
`define VFDSC_PARAMS_SVH
// ----------------------------------------
// APB register byte offsets
// ----------------------------------------
`define VFDSC_CTRL_OFS      12'h000
`define VFDSC_STAT_OFS      12'h004
`define VFDSC_DIM_OFS       12'h008
`define VFDSC_SEG1_OFS      12'h00C
`define VFDSC_SEG2_OFS      12'h010
`define VFDSC_SEG3_OFS      12'h014
`define VFDSC_CTRL_RST      32'h0000_0000
`define VFDSC_CTRL_TRI_BIT  0
// ----------------------------------------
// Frame layout
// ----------------------------------------
`define VFDSC_FRAME_BITS    30
`define VFDSC_CODE_LSB      27
`define VFDSC_DIM_LSB       17
`define VFDSC_MIN_BITS      6'h03
`define VFDSC_DUTY_MAX      10'h3F8
`define VFDSC_LATCH_RST     27'h000_0000
`define VFDSC_DIM_RST       10'h000
// ----------------------------------------
// Timing
// ----------------------------------------
`define VFDSC_CLK_MHZ       200
`define VFDSC_STOP_MIN_NS   2400
`define VFDSC_STOP_MAX_NS   3600
`define VFDSC_BIT_DIV       242
`define VFDSC_ROW_DIV       7800
`endif

// ---- logic/vfdsc_pkg.sv ----
// Types shared by the serial command port and its display driver.
// Assumes vfdsc_params.svh is compiled alongside.
package vfdsc_pkg;
    typedef enum logic [2:0] {
        VFDSC_FN_SEG_ALL = 3'h0,
        VFDSC_FN_SEG_G1  = 3'h1,
        VFDSC_FN_SEG_G2  = 3'h2,
        VFDSC_FN_SEG_G3  = 3'h3,
        VFDSC_FN_DIM     = 3'h4,
        VFDSC_FN_STOP    = 3'h5,
        VFDSC_FN_RD_SW   = 3'h6,
        VFDSC_FN_RD_CONV = 3'h7
    } vfdsc_func_type;

    typedef enum logic [1:0] {
        VFDSC_RB_IDLE  = 2'b00,
        VFDSC_RB_ARMED = 2'b01,
        VFDSC_RB_SEND  = 2'b10
    } vfdsc_rb_type;

    typedef struct packed {
        vfdsc_func_type code;
        logic [26:0]    payload;
    } vfdsc_frame_type;

    typedef struct packed {
        logic [26:0] g3;
        logic [26:0] g2;
        logic [26:0] g1;
    } vfdsc_bank_type;
endpackage

// ---- logic/vfdsc_dimmer.sv ----
// Grid multiplex and digital dimming for the segment latches.
// Assumes one system clock; grid drivers are active low.
`timescale 1ns/10ps
`default_nettype none
`include "vfdsc_params.svh"
module vfdsc_dimmer
    import vfdsc_pkg::*;
#(
    parameter int BIT_DIV = `VFDSC_BIT_DIV
) (
    // Clock and reset
    input  wire logic           sys_clk_in,
    input  wire logic           sys_rst_in,
    // Control
    input  wire logic           triplex_in,
    input  wire logic [9:0]     duty_in,
    input  wire vfdsc_bank_type bank_in,
    // Drivers
    output logic [2:0]          grid_n_out,
    output logic [26:0]         seg_out
);
    initial begin
        if (BIT_DIV < 1 || BIT_DIV > 65535) begin
            $error("BIT_DIV out of range");
        end
    end

    logic [15:0] div_q;
    logic [9:0]  phase_q;
    logic [1:0]  grid_q;
    logic        tick;
    logic [9:0]  duty_eff;
    logic        lit;
    logic [26:0] pattern;

    assign tick     = (div_q == 16'(BIT_DIV - 1));
    // Top codes all saturate to the same duty
    assign duty_eff = (duty_in > `VFDSC_DUTY_MAX) ? `VFDSC_DUTY_MAX : duty_in;
    assign lit      = (phase_q < duty_eff);

    always_comb begin
        unique case (grid_q)
            2'd0:    pattern = bank_in.g1;
            2'd1:    pattern = bank_in.g2;
            default: pattern = bank_in.g3;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || tick) begin
            div_q <= 16'h0000;
        end else begin
            div_q <= div_q + 16'h0001;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            phase_q <= 10'h000;
            grid_q  <= 2'd0;
        end else if (tick) begin
            phase_q <= phase_q + 10'h001;
            if (phase_q == 10'h3FF) begin
                grid_q <= (grid_q == (triplex_in ? 2'd2 : 2'd1)) ? 2'd0 : grid_q + 2'd1;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            grid_n_out <= 3'b111;
            seg_out    <= 27'h000_0000;
        end else begin
            grid_n_out <= lit ? ~(3'b001 << grid_q) : 3'b111;
            seg_out    <= lit ? pattern : 27'h000_0000;
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    AST_DIM_SAT_OFF: assert property (
        (phase_q >= `VFDSC_DUTY_MAX) |=> (grid_n_out == 3'b111))
        else $error("grid lit beyond saturated duty");
endmodule // vfdsc_dimmer
`default_nettype wire

// ---- logic/vfdsc_cmd_port.sv ----
// Serial command port of a duplex/triplex display controller.
// Assumes select, serial clock and data arrive asynchronously.
//
// Summary of operation
// - Power-up clears every shift register and latch to zero.
// - Dimming duty is zero after reset, so nothing is lit.
// - After reset: segments low, grids high, rows low, interrupt low.
// - Data is taken or shown only while select is high.
// - Each rising serial clock outside a readback frame shifts the data level in.
// - Falling select latches the shifted frame, no extra clocks.
// - Readback shows the next output bit at each rising serial clock.
// - Data pin drives during readback and is released when select falls.
// - Codes: 0 all grids, 1-3 one grid, 4 dim, 5 stop, 6-7 read.
// - Code zero copies one pattern into all three grid latches.
// - Codes 1-3 update only the named grid latch.
// - Segment frame is 27 payload bits then 3 code bits.
// - Segment output is high when its active-grid bit is one and the grid is lit.
// - Dimming frame is ten bits, LSB first, then 3 code bits.
// - Duty is value/1024, saturating at 1016/1024.
// - Scanning ceases 2.4 to 3.6 us after a stop is latched, unless a change while scanning made that stop only disarm.
// - When a switch readback command is latched: counter reset, interrupt low unless a new event arrives in that cycle.
`timescale 1ns/10ps
`default_nettype none
`include "vfdsc_params.svh"
module vfdsc_cmd_port
    import vfdsc_pkg::*;
#(
    parameter int BIT_DIV = `VFDSC_BIT_DIV,
    parameter int ROW_DIV = `VFDSC_ROW_DIV
) (
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        sys_rst_in,
    // Serial link pins
    input  wire logic        sclk_in,
    input  wire logic        select_in,
    input  wire logic        sdata_in,
    output logic             sdata_out,
    output logic             sdata_oe_out,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Display drivers
    output logic [26:0]      seg_out,
    output logic [2:0]       grid_n_out,
    // Keyscan and encoder side
    input  wire logic        key_change_in,
    input  wire logic        int_event_in,
    input  wire logic [24:0] key_bits_in,
    input  wire logic        rotation_dir_in,
    input  wire logic [2:0]  contact_count_in,
    input  wire logic [47:0] conv_result_in,
    output logic [4:0]       scan_row_out,
    output logic             keyscan_active_out,
    output logic             interrupt_out,
    output logic             encoder_clear_out
);
    localparam int STOP_CYC = (`VFDSC_STOP_MIN_NS * `VFDSC_CLK_MHZ + 999) / 1000;
    localparam int STOP_MAX = (`VFDSC_STOP_MAX_NS * `VFDSC_CLK_MHZ) / 1000;

    initial begin
        if (ROW_DIV < 1 || ROW_DIV > 65535 || STOP_CYC > STOP_MAX) begin
            $error("vfdsc_cmd_port parameters out of range");
        end
    end

    // ----------------------------------------
    // Pin synchronisers and edges
    // ----------------------------------------
    logic sclk_s1, sclk_s2, sclk_s3;
    logic sel_s1, sel_s2, sel_s3;
    logic sdat_s1, sdat_s2;
    logic sclk_rise, sel_fall, sel_rise;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            {sclk_s1, sclk_s2, sclk_s3} <= 3'b000;
            {sel_s1, sel_s2, sel_s3}    <= 3'b000;
            {sdat_s1, sdat_s2}          <= 2'b00;
        end else begin
            {sclk_s1, sclk_s2, sclk_s3} <= {sclk_in, sclk_s1, sclk_s2};
            {sel_s1, sel_s2, sel_s3}    <= {select_in, sel_s1, sel_s2};
            {sdat_s1, sdat_s2}          <= {sdata_in, sdat_s1};
        end
    end

    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign sel_fall  = ~sel_s2 & sel_s3;
    assign sel_rise  = sel_s2 & ~sel_s3;

    // ----------------------------------------
    // Input shift register and frame decode
    // ----------------------------------------
    vfdsc_rb_type    rb_q;
    vfdsc_frame_type frame;
    logic [29:0]     in_sr_q;
    logic [5:0]      nbits_q;
    logic            frame_ok;
    logic            shift_en;

    assign shift_en = sclk_rise & sel_s2 & (rb_q != VFDSC_RB_SEND);
    assign frame    = vfdsc_frame_type'(in_sr_q);
    assign frame_ok = sel_fall & (rb_q != VFDSC_RB_SEND) & (nbits_q >= `VFDSC_MIN_BITS);

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || sel_fall) begin
            in_sr_q <= 30'h0000_0000;
            nbits_q <= 6'h00;
        end else if (shift_en) begin
            // Newest bit enters at the top so the code lands at [29:27]
            in_sr_q <= {sdat_s2, in_sr_q[29:1]};
            nbits_q <= (nbits_q == 6'h3F) ? nbits_q : nbits_q + 6'h01;
        end
    end

    // ----------------------------------------
    // Segment and dimming latches
    // ----------------------------------------
    vfdsc_bank_type bank_q;
    logic [9:0]     dim_q;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            bank_q <= {3{`VFDSC_LATCH_RST}};
        end else if (frame_ok) begin
            unique case (frame.code)
                VFDSC_FN_SEG_ALL: bank_q <= {3{frame.payload}};
                VFDSC_FN_SEG_G1:  bank_q.g1 <= frame.payload;
                VFDSC_FN_SEG_G2:  bank_q.g2 <= frame.payload;
                VFDSC_FN_SEG_G3:  bank_q.g3 <= frame.payload;
                VFDSC_FN_DIM, VFDSC_FN_STOP, VFDSC_FN_RD_SW, VFDSC_FN_RD_CONV: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            dim_q <= `VFDSC_DIM_RST;
        end else if (frame_ok && frame.code == VFDSC_FN_DIM) begin
            dim_q <= in_sr_q[`VFDSC_DIM_LSB +: 10];
        end
    end

    // ----------------------------------------
    // Readback
    // ----------------------------------------
    logic [47:0] out_sr_q;
    logic        snap_sw;

    assign snap_sw = frame_ok & (frame.code == VFDSC_FN_RD_SW);

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            rb_q <= VFDSC_RB_IDLE;
        end else begin
            unique case (rb_q)
                VFDSC_RB_IDLE: begin
                    if (frame_ok && frame.code[2:1] == 2'b11) begin
                        rb_q <= VFDSC_RB_ARMED;
                    end
                end
                VFDSC_RB_ARMED: begin
                    if (sel_rise) begin
                        rb_q <= VFDSC_RB_SEND;
                    end
                end
                VFDSC_RB_SEND: begin
                    if (sel_fall) begin
                        rb_q <= VFDSC_RB_IDLE;
                    end
                end
                default: rb_q <= VFDSC_RB_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            out_sr_q <= 48'h0000_0000_0000;
        end else if (frame_ok && frame.code == VFDSC_FN_RD_SW) begin
            out_sr_q <= {19'h0_0000, contact_count_in, rotation_dir_in, key_bits_in};
        end else if (frame_ok && frame.code == VFDSC_FN_RD_CONV) begin
            out_sr_q <= conv_result_in;
        end else if (rb_q == VFDSC_RB_SEND && sclk_rise) begin
            out_sr_q <= {1'b0, out_sr_q[47:1]};
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            sdata_out    <= 1'b0;
            sdata_oe_out <= 1'b0;
        end else begin
            sdata_out    <= out_sr_q[0];
            // Drive only inside the readback frame, never across a select fall
            sdata_oe_out <= (rb_q == VFDSC_RB_SEND) & sel_s2 & ~sel_fall;
        end
    end

    // ----------------------------------------
    // Interrupt and encoder clear
    // ----------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            interrupt_out     <= 1'b0;
            encoder_clear_out <= 1'b0;
        end else begin
            encoder_clear_out <= snap_sw;
            // A new event in the clear cycle wins
            if (int_event_in) begin
                interrupt_out <= 1'b1;
            end else if (snap_sw) begin
                interrupt_out <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Keyscan run and stop
    // ----------------------------------------
    logic        scan_q;
    logic        rearm_q;
    logic [9:0]  stop_cnt_q;
    logic        stop_go;
    logic [15:0] row_div_q;

    assign stop_go = frame_ok & (frame.code == VFDSC_FN_STOP) & ~rearm_q;
    assign keyscan_active_out = scan_q;

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            stop_cnt_q <= 10'h000;
        end else if (stop_go) begin
            stop_cnt_q <= 10'(STOP_CYC);
        end else if (stop_cnt_q != 10'h000) begin
            stop_cnt_q <= stop_cnt_q - 10'h001;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            scan_q  <= 1'b0;
            rearm_q <= 1'b0;
        end else begin
            if (key_change_in) begin
                scan_q <= 1'b1;
            end else if (stop_cnt_q == 10'h001) begin
                scan_q <= 1'b0;
            end
            // A change while scanning makes the next stop only disarm
            if (key_change_in && scan_q) begin
                rearm_q <= 1'b1;
            end else if (frame_ok && frame.code == VFDSC_FN_STOP) begin
                rearm_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !scan_q) begin
            row_div_q    <= 16'h0000;
            scan_row_out <= 5'b00000;
        end else if (row_div_q == 16'(ROW_DIV - 1)) begin
            row_div_q    <= 16'h0000;
            scan_row_out <= (scan_row_out == 5'b00000 || scan_row_out[4]) ? 5'b00001
                                                                         : scan_row_out << 1;
        end else begin
            row_div_q <= row_div_q + 16'h0001;
        end
    end

    // ----------------------------------------
    // APB registers
    // ----------------------------------------
    logic        tri_q;
    logic        setup;
    logic        hit;
    logic [31:0] rd_val;

    assign setup   = psel & ~penable;
    assign pready  = 1'b1;

    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            `VFDSC_CTRL_OFS: rd_val = {31'h0000_0000, tri_q};
            `VFDSC_STAT_OFS: rd_val = {26'h000_0000, interrupt_out, scan_q,
                                      rb_q, in_sr_q[29:28]};
            `VFDSC_DIM_OFS:  rd_val = {22'h00_0000, dim_q};
            `VFDSC_SEG1_OFS: rd_val = {5'h00, bank_q.g1};
            `VFDSC_SEG2_OFS: rd_val = {5'h00, bank_q.g2};
            `VFDSC_SEG3_OFS: rd_val = {5'h00, bank_q.g3};
            default:         hit    = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_val;
            pslverr <= ~hit;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            tri_q <= 1'(`VFDSC_CTRL_RST);
        end else if (psel && penable && pwrite && paddr == `VFDSC_CTRL_OFS) begin
            tri_q <= pwdata[`VFDSC_CTRL_TRI_BIT];
        end
    end

    vfdsc_dimmer #(
        .BIT_DIV (BIT_DIV)
    ) u_dimmer (
        .sys_clk_in (sys_clk_in),
        .sys_rst_in (sys_rst_in),
        .triplex_in (tri_q),
        .duty_in    (dim_q),
        .bank_in    (bank_q),
        .grid_n_out (grid_n_out),
        .seg_out    (seg_out)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence seg_frame(logic [2:0] c);
        frame_ok && frame.code == c;
    endsequence

    sequence read_done;
        rb_q == VFDSC_RB_SEND ##1 sel_fall;
    endsequence

    AST_RESET_STATE: assert property (
        $past(sys_rst_in) |-> (bank_q == '0 && in_sr_q == '0 && !interrupt_out))
        else $error("state not cleared by reset");
    AST_DIM_RESET: assert property (
        $past(sys_rst_in) |-> (dim_q == 10'h000 && scan_row_out == 5'b00000))
        else $error("dimming not zero after reset");
    AST_SHIFT_IN: assert property (
        shift_en |=> in_sr_q[29] == $past(sdat_s2) && in_sr_q[28] == $past(in_sr_q[29]))
        else $error("serial bit not shifted in");
    AST_ALL_GRIDS: assert property (
        seg_frame(3'h0) |=> (bank_q.g1 == $past(frame.payload) && bank_q.g2 == bank_q.g1
                             && bank_q.g3 == bank_q.g1))
        else $error("grid latches differ after broadcast");
    AST_ONE_GRID: assert property (
        seg_frame(3'h2) |=> ($stable(bank_q.g1) && $stable(bank_q.g3)
                             && bank_q.g2 == $past(frame.payload)))
        else $error("wrong grid latch updated");
    AST_RELEASE: assert property (
        read_done |=> !sdata_oe_out [*2])
        else $error("data pin still driven after select fell");
    AST_OE_SELECT: assert property (
        sdata_oe_out |-> $past(sel_s2) && $past(rb_q) == VFDSC_RB_SEND)
        else $error("data pin driven outside readback frame");
    AST_READ_BIT: assert property (
        (rb_q == VFDSC_RB_SEND && sclk_rise) |=> ##1 sdata_out == $past(out_sr_q[1], 2))
        else $error("readback bit not advanced");
    AST_STOP_TIME: assert property (
        (stop_go && scan_q && !key_change_in) |-> scan_q [*8] ##[1:712] !scan_q)
        else $error("scanning did not stop in time");
    AST_INT_CLEAR: assert property (
        (snap_sw && !int_event_in) |=> (!interrupt_out && encoder_clear_out))
        else $error("interrupt not cleared on switch readback");
endmodule // vfdsc_cmd_port
`default_nettype wire

// ---- bench/vfdsc_host.sv ----
// Host side of the three-wire link: sends frames and clocks readback.
// Assumes the bench resolves the shared data wire into sdata_in.
`timescale 1ns/10ps
`default_nettype none
module vfdsc_host (
    // Clock
    input  wire logic clk_in,
    // Link pins
    output logic      sclk_out,
    output logic      select_out,
    output logic      sdata_out,
    input  wire logic sdata_in
);
    // ----------------------------------------
    // Link timing, 13 system clocks a bit when sending, 19 when fetching
    // ----------------------------------------
    initial begin
        sclk_out = 1'h0;
        select_out = 1'h0;
        sdata_out = 1'h0;
    end

    task automatic half(input int k);
        repeat (k) @(posedge clk_in);
    endtask

    // Serial clock stands still outside frames
    task automatic send(input logic [29:0] b, input int n);
        half(1);
        select_out <= 1'h1;
        half(7);
        for (int i = 0; i < n; i++) begin
            sdata_out <= b[i];
            half(6);
            sclk_out <= 1'h1;
            half(7);
            sclk_out <= 1'h0;
        end
        half(6);
        select_out <= 1'h0;
        // Released line shows the inverse, never a stale bit
        sdata_out <= ~b[n-1];
        half(30);
    endtask

    // Sampling long after each edge hides the pin latency
    task automatic fetch(input int n, output logic [47:0] v);
        v = '0;
        half(1);
        select_out <= 1'h1;
        half(13);
        for (int i = 0; i < n; i++) begin
            v[i] = sdata_in;
            sclk_out <= 1'h1;
            half(13);
            sclk_out <= 1'h0;
            half(6);
        end
        select_out <= 1'h0;
        half(30);
    endtask
endmodule // vfdsc_host
`default_nettype wire

// ---- bench/vfd_serial_command_port_test.sv ----
// Bench for the serial command port: APB access and host frames.
// Assumes the design files and vfdsc_host are compiled before it.
`timescale 1ns/10ps
`default_nettype none
`include "vfdsc_params.svh"
module vfd_serial_command_port_test
    import vfdsc_pkg::*;
;
    // ----------------------------------------
    // Signals, clock and instances
    // ----------------------------------------
    logic        sys_clk_in = 1'h0;
    logic        sys_rst_in = 1'h1;
    logic        psel = 1'h0;
    logic        penable = 1'h0;
    logic        pwrite = 1'h0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic        key_change_in = 1'h0;
    logic        int_event_in = 1'h0;
    logic [24:0] key_bits_in = 25'h1A5_C3E1;
    logic        rotation_dir_in = 1'h1;
    logic [2:0]  contact_count_in = 3'h5;
    logic [47:0] conv_result_in = 48'h8E31_07F4_C2A9;
    logic        sclk_in, select_in, host_sd, sdata_out, sdata_oe_out, pready, pslverr;
    logic        keyscan_active_out, interrupt_out, encoder_clear_out, err_q;
    logic [31:0] prdata, rd_q;
    logic [26:0] seg_out;
    logic [2:0]  grid_n_out;
    logic [4:0]  scan_row_out;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          clr_cnt = 0;
    wire         sdata_in = sdata_oe_out ? sdata_out : host_sd;

    always #2.5 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) clr_cnt <= clr_cnt + int'(encoder_clear_out);

    vfdsc_cmd_port #(.BIT_DIV(2), .ROW_DIV(4)) i_vfdsc_cmd_port (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .sclk_in(sclk_in),
        .select_in(select_in), .sdata_in(sdata_in), .sdata_out(sdata_out),
        .sdata_oe_out(sdata_oe_out), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .seg_out(seg_out), .grid_n_out(grid_n_out),
        .key_change_in(key_change_in), .int_event_in(int_event_in),
        .key_bits_in(key_bits_in), .rotation_dir_in(rotation_dir_in),
        .contact_count_in(contact_count_in), .conv_result_in(conv_result_in),
        .scan_row_out(scan_row_out), .keyscan_active_out(keyscan_active_out),
        .interrupt_out(interrupt_out), .encoder_clear_out(encoder_clear_out));
    vfdsc_host i_vfdsc_host (.clk_in(sys_clk_in), .sclk_out(sclk_in), .select_out(select_in),
        .sdata_out(host_sd), .sdata_in(sdata_in));

    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic guard(input logic ok);
        if (!ok) begin
            chk(48'h0, 48'h1);
            close_out();
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk_in);
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_in);
        penable <= 1'h1;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        guard(n < 50);
    endtask

    task automatic wait_grid(input logic lvl);
        int n;
        n = 0;
        while (grid_n_out[0] !== lvl && n < 9000) begin
            tick(1);
            n++;
        end
        guard(n < 9000);
    endtask

    function automatic logic [26:0] pat(input int g);
        return (g == 0) ? 27'h555_5555 : 27'h123_4560 + 27'(g);
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        logic [47:0] v;
        int          n;
        tick(5);
        sys_rst_in <= 1'h0;
        tick(1);
        #1;
        chk({seg_out, grid_n_out, scan_row_out, interrupt_out, sdata_oe_out}, 48'h380);
        apb(1'h0, `VFDSC_DIM_OFS, 32'h0);
        chk(rd_q, 48'h0);
        apb(1'h0, 12'h018, 32'h0);
        chk(err_q, 48'h1);
        apb(1'h1, `VFDSC_CTRL_OFS, 32'h1);
        apb(1'h0, `VFDSC_CTRL_OFS, 32'h0);
        chk({err_q, rd_q}, 48'h1);
        for (int g = 0; g < 4; g++) begin
            i_vfdsc_host.send({g[2:0], pat(g)}, 30);
            for (int k = 1; k < 4; k++) begin
                apb(1'h0, `VFDSC_SEG1_OFS + 12'(4 * k - 4), 32'h0);
                chk(rd_q, pat((k <= g) ? k : 0));
            end
        end
        for (int d = 0; d < 2; d++) begin
            v = d ? 48'h3FF : 48'h155;
            i_vfdsc_host.send(30'({VFDSC_FN_DIM, v[9:0]}), 13);
            apb(1'h0, `VFDSC_DIM_OFS, 32'h0);
            if (d == 0) chk(rd_q, v);
            wait_grid(1'h1);
            wait_grid(1'h0);
            n = 0;
            while (grid_n_out[0] === 1'h0 && n < 3000) begin
                tick(1);
                n++;
                if (n == 8) chk(seg_out, pat(1));
            end
            guard(n < 3000);
            chk(n, d ? 48'd2032 : 48'd682);
        end
        key_change_in <= 1'h1;
        tick(1);
        key_change_in <= 1'h0;
        tick(10);
        chk(keyscan_active_out, 48'h1);
        key_change_in <= 1'h1;
        tick(1);
        key_change_in <= 1'h0;
        i_vfdsc_host.send(30'(VFDSC_FN_STOP), 3);
        tick(700);
        chk(keyscan_active_out, 48'h1);
        i_vfdsc_host.send(30'(VFDSC_FN_STOP), 3);
        tick(450);
        chk(keyscan_active_out, 48'h1);
        n = 0;
        while (keyscan_active_out === 1'h1 && n < 300) begin
            tick(1);
            n++;
        end
        guard(n < 300);
        chk(n < 244, 48'h1);
        tick(2);
        chk(scan_row_out, 48'h0);
        int_event_in <= 1'h1;
        tick(1);
        int_event_in <= 1'h0;
        tick(5);
        chk(interrupt_out, 48'h1);
        for (int c = 6; c < 8; c++) begin
            i_vfdsc_host.send(30'(c), 3);
            chk({clr_cnt[3:0], interrupt_out}, 48'h2);
            i_vfdsc_host.fetch(c == 6 ? 29 : 48, v);
            chk(v, c == 6 ? {contact_count_in, rotation_dir_in, key_bits_in} : conv_result_in);
            chk(sdata_oe_out, 48'h0);
        end
        close_out();
    end
endmodule // vfd_serial_command_port_test
`default_nettype wire
